// File: rtl/scrx_pkg.sv
// Constants, types and the rule summary for the stack, call and reset executor
// Behaviour
// RQ1 - Pop drops top entry, nothing else changes
// RQ2 - After pop, earlier pushed entry becomes top
// RQ3 - Push writes current PC plus 2 on top
// RQ4 - Push keeps old top one level down
// RQ5 - Call prefix 11011, signed 11-bit word offset
// RQ6 - Call pushes return address before PC change
// RQ7 - Call target is PC plus 2 plus 2n
// RQ8 - Call offsets span -1024 through 1023 words
// RQ9 - Call takes two cycles, second is flushed
// RQ10 - Reset opcode acts like external master clear
// RQ11 - Zero word or 1111 prefix is NOP
// RQ12 - Push in second phase, pop in third
package scrx_pkg;
  localparam int PC_W = 21;
  localparam int STK_DEPTH = 31;
  localparam int PTR_W = 5;
  localparam int OFS_MSB = 10;
  localparam int OFS_EXT = PC_W - OFS_MSB - 2;
  localparam int CALL_LSB = 11;
  localparam int ALT_NOP_LSB = 12;

  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_ZERO = 21'h000000;
  localparam logic [PTR_W-1:0] PTR_ZERO = 5'h00;
  localparam logic [PTR_W-1:0] PTR_ONE = 5'h01;
  localparam logic [PTR_W-1:0] PTR_TWO = 5'h02;
  localparam logic [PTR_W-1:0] PTR_FULL = 5'h1F;

  localparam logic [15:0] OPC_NOP = 16'h0000;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_POP = 16'h0006;
  localparam logic [15:0] OPC_RESET = 16'h00FF;
  localparam logic [4:0] CALL_PREFIX = 5'h1B;
  localparam logic [3:0] ALT_NOP_PREFIX = 4'hF;
  localparam logic [OFS_MSB:0] OFS_MOST_NEG = 11'h400;
  localparam logic [OFS_MSB:0] OFS_MOST_POS = 11'h3FF;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } scrx_phase_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_NOP = 3'b001,
    OP_PUSH = 3'b010,
    OP_POP = 3'b011,
    OP_CALL = 3'b100,
    OP_RST = 3'b101
  } scrx_op_t;

  typedef struct packed {
    logic load;
    logic [PC_W-1:0] addr;
    logic flush;
  } scrx_fetch_t;
endpackage

// File: rtl/scrx_phase.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/1ns
module scrx_phase
  import scrx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Current phase
  output scrx_phase_t phase
);
  scrx_phase_t ph_d;
  scrx_phase_t ph_q;

  always_comb begin
    unique case (ph_q)
      PH_Q1: ph_d = PH_Q2;
      PH_Q2: ph_d = PH_Q3;
      PH_Q3: ph_d = PH_Q4;
      PH_Q4: ph_d = PH_Q1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ph_q <= PH_Q1;
    end else begin
      ph_q <= ph_d;
    end
  end

  assign phase = ph_q;

  property p_phase_wrap;
    @(posedge core_clk) disable iff (rst)
    ph_q == PH_Q4 |=> ph_q == PH_Q1;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap to first"); // RQ12
endmodule

// File: rtl/scrx_exec.sv
// Executor for no-op, push, pop, relative call and software reset instructions
`timescale 1ns/1ns
module scrx_exec
  import scrx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Instruction and its address from fetch
  input wire logic [15:0] instr_word,
  input wire logic [PC_W-1:0] pc_cur,
  // Program counter control to fetch
  output scrx_fetch_t fetch_ctl,
  // Return stack view
  output logic [PC_W-1:0] stack_top_entry,
  output logic [PTR_W-1:0] stack_level,
  // Core-wide reset request
  output logic core_reset
);
  scrx_phase_t phase;
  logic srst;
  scrx_op_t op_d;
  scrx_op_t op_q;
  logic [PC_W-1:0] pc_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] tgt_d;
  logic [PC_W-1:0] tgt_q;
  logic flush_d;
  logic flush_q;
  logic rst_req_d;
  logic rst_req_q;
  logic [PC_W-1:0] ret_addr;
  logic [PC_W-1:0] ofs_ext;
  logic [PTR_W-1:0] ptr_d;
  logic [PTR_W-1:0] ptr_q;
  logic [PC_W-1:0] top_d;
  logic [PC_W-1:0] top_q;
  logic [PC_W-1:0] below;
  logic [PC_W-1:0] mem [0:STK_DEPTH-1];
  logic wr_en;
  logic push_evt;
  logic pop_evt;
  logic pc_load;
  logic [PC_W-1:0] ofs_ext_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Master clear from the pin or from the reset instruction
  assign srst = rst | rst_req_q;

  scrx_phase u_phase (
    .core_clk(core_clk),
    .rst(srst),
    .phase(phase)
  );

  function automatic scrx_op_t decode(input logic [15:0] w);
    scrx_op_t r;
    r = OP_NONE;
    // RQ11 no-op forms
    if (w == OPC_NOP || w[15:ALT_NOP_LSB] == ALT_NOP_PREFIX) begin
      r = OP_NOP;
    end else if (w == OPC_PUSH) begin
      r = OP_PUSH;
    end else if (w == OPC_POP) begin
      r = OP_POP;
    end else if (w == OPC_RESET) begin
      r = OP_RST;
    // RQ5 call prefix match
    end else if (w[15:CALL_LSB] == CALL_PREFIX) begin
      r = OP_CALL;
    end
    return r;
  endfunction

  // RQ8 full signed range
  // RQ5 sign-extend word offset
  assign ofs_ext = {{OFS_EXT{instr_word[OFS_MSB]}}, instr_word[OFS_MSB:0], 1'b0};
  // RQ3 return address
  assign ret_addr = pc_q + PC_STEP;

  always_comb begin
    op_d = op_q;
    pc_d = pc_q;
    tgt_d = tgt_q;
    flush_d = flush_q;
    rst_req_d = 1'b0;
    if (phase == PH_Q1) begin
      // RQ9 second call cycle executes nothing
      op_d = flush_q ? OP_NOP : decode(instr_word);
      pc_d = pc_cur;
      // RQ7 target from incremented PC
      tgt_d = pc_cur + PC_STEP + ofs_ext;
    end
    // RQ9 redirect cycle follows a call
    if (phase == PH_Q4) begin
      flush_d = (op_q == OP_CALL);
    end
    // RQ10 software master clear
    if (phase == PH_Q2 && op_q == OP_RST) begin
      rst_req_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      op_q <= OP_NONE;
      pc_q <= PC_ZERO;
      tgt_q <= PC_ZERO;
      flush_q <= 1'b0;
    end else begin
      op_q <= op_d;
      pc_q <= pc_d;
      tgt_q <= tgt_d;
      flush_q <= flush_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rst_req_q <= 1'b0;
    end else begin
      rst_req_q <= rst_req_d;
    end
  end

  // RQ12 stack update phases
  assign push_evt = (phase == PH_Q2) && (op_q == OP_PUSH || op_q == OP_CALL);
  assign pop_evt = (phase == PH_Q3) && (op_q == OP_POP);
  assign below = (ptr_q >= PTR_TWO) ? mem[ptr_q - PTR_TWO] : PC_ZERO;

  always_comb begin
    ptr_d = ptr_q;
    top_d = top_q;
    wr_en = 1'b0;
    // RQ4 new entry above old top
    if (push_evt && ptr_q != PTR_FULL) begin
      wr_en = 1'b1;
      ptr_d = ptr_q + PTR_ONE;
      top_d = ret_addr;
    // RQ1 discard top value
    end else if (pop_evt && ptr_q != PTR_ZERO) begin
      ptr_d = ptr_q - PTR_ONE;
      // RQ2 expose previous entry
      top_d = below;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ptr_q <= PTR_ZERO;
      top_q <= PC_ZERO;
    end else begin
      ptr_q <= ptr_d;
      top_q <= top_d;
    end
  end

  // Entries survive a master clear; only the level and the top register are cleared
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[ptr_q] <= ret_addr;
    end
  end

  // RQ6 PC written after the push
  assign pc_load = (phase == PH_Q4) && (op_q == OP_CALL);

  assign fetch_ctl = '{load: pc_load, addr: tgt_q, flush: flush_q};
  assign stack_top_entry = top_q;
  assign stack_level = ptr_q;
  assign core_reset = rst_req_q;

  property p_pop_level;
    pop_evt && ptr_q != PTR_ZERO |=> ptr_q == $past(ptr_q) - PTR_ONE && !fetch_ctl.load;
  endproperty
  a_pop_level: assert property (p_pop_level) else $error("pop did not lower stack level by one"); // RQ1

  property p_pop_top;
    pop_evt && ptr_q != PTR_ZERO |=> stack_top_entry == $past(below);
  endproperty
  a_pop_top: assert property (p_pop_top) else $error("pop did not expose previous entry"); // RQ2

  property p_push_top;
    push_evt && op_q == OP_PUSH && ptr_q != PTR_FULL |=> stack_top_entry == $past(pc_q) + PC_STEP;
  endproperty
  a_push_top: assert property (p_push_top) else $error("push top is not PC plus 2"); // RQ3

  property p_push_keep;
    push_evt && ptr_q != PTR_FULL && ptr_q != PTR_ZERO |=> below == $past(top_q);
  endproperty
  a_push_keep: assert property (p_push_keep) else $error("push lost previous top"); // RQ4

  property p_call_decode;
    phase == PH_Q1 && !flush_q && instr_word[15:CALL_LSB] == CALL_PREFIX |=> op_q == OP_CALL;
  endproperty
  a_call_decode: assert property (p_call_decode) else $error("call prefix not decoded"); // RQ5

  property p_call_order;
    push_evt && op_q == OP_CALL |-> !fetch_ctl.load ##2 fetch_ctl.load;
  endproperty
  a_call_order: assert property (p_call_order) else $error("call PC write not two phases after push"); // RQ6

  property p_call_push;
    push_evt && op_q == OP_CALL && ptr_q != PTR_FULL |=>
      stack_top_entry == $past(pc_q) + PC_STEP && stack_level == $past(ptr_q) + PTR_ONE;
  endproperty
  a_call_push: assert property (p_call_push) else $error("call did not push return address"); // RQ6

  // A full stack refuses the push, so the return address is not on top then
  property p_call_target;
    fetch_ctl.load && stack_level != PTR_FULL |-> fetch_ctl.addr == stack_top_entry + ofs_ext_q;
  endproperty
  always_ff @(posedge core_clk) begin
    if (phase == PH_Q1) begin
      ofs_ext_q <= ofs_ext;
    end
  end
  a_call_target: assert property (p_call_target) else $error("call target wrong"); // RQ7

  property p_call_reach;
    phase == PH_Q1 && !flush_q && instr_word[15:CALL_LSB] == CALL_PREFIX &&
      instr_word[OFS_MSB:0] == OFS_MOST_NEG |=> tgt_q == pc_q + PC_STEP - {OFS_MOST_NEG, 1'b0};
  endproperty
  a_call_reach: assert property (p_call_reach) else $error("most negative offset not reached"); // RQ8

  property p_call_flush;
    fetch_ctl.load |=> fetch_ctl.flush [*4] ##1 !fetch_ctl.flush;
  endproperty
  a_call_flush: assert property (p_call_flush) else $error("second call cycle not one full cycle"); // RQ9

  property p_soft_reset;
    @(posedge core_clk) disable iff (rst)
    phase == PH_Q2 && op_q == OP_RST && !rst_req_q |=> core_reset ##1
      (!core_reset && phase == PH_Q1 && stack_level == PTR_ZERO && !fetch_ctl.flush);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset opcode did not clear state"); // RQ10

  property p_nop_quiet;
    op_q == OP_NOP && phase != PH_Q1 |-> !push_evt && !pop_evt && !fetch_ctl.load && $stable(ptr_q);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("no-op changed state"); // RQ11

  property p_phase_use;
    ptr_q != $past(ptr_q) |-> $past(phase) == PH_Q2 || $past(phase) == PH_Q3;
  endproperty
  a_phase_use: assert property (p_phase_use) else $error("stack moved in wrong phase"); // RQ12

  c_push: cover property (push_evt && op_q == OP_PUSH);
  c_pop: cover property (pop_evt && ptr_q != PTR_ZERO);
  c_call_pos: cover property (fetch_ctl.load ##1 fetch_ctl.flush);
  c_call_max: cover property (phase == PH_Q1 && instr_word[15:CALL_LSB] == CALL_PREFIX &&
    instr_word[OFS_MSB:0] == OFS_MOST_POS);
  c_soft: cover property (@(posedge core_clk) disable iff (rst) core_reset);
endmodule

// File: test/scrx_fetch_model.sv
// Behavioural fetch side: program counter that follows load, flush and core reset
`timescale 1ns/1ns
module scrx_fetch_model
  import scrx_pkg::*;
#(
  parameter logic [PC_W-1:0] START_PC = 21'h000124
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // From executor
  input wire scrx_fetch_t fetch_ctl,
  input wire logic core_reset,
  // Address of current instruction
  output logic [PC_W-1:0] pc_cur
);
  logic [1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (rst || core_reset) begin
      cnt_q <= 2'h0;
      pc_cur <= START_PC;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      // Flushed cycle leaves the target address in place
      if (fetch_ctl.load) begin
        pc_cur <= fetch_ctl.addr;
      end else if (cnt_q == 2'h3 && !fetch_ctl.flush) begin
        pc_cur <= pc_cur + PC_STEP;
      end
    end
  end
endmodule

// File: test/tb_scrx_exec.sv
// Testbench for the stack, call and reset executor
`timescale 1ns/1ns
module tb_scrx_exec
  import scrx_pkg::*;
;
  localparam logic [PC_W-1:0] START = 21'h000124;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] instr_word = OPC_NOP;
  logic [PC_W-1:0] pc_cur;
  logic [PC_W-1:0] stack_top_entry;
  logic [PC_W-1:0] exp_pc;
  logic [PC_W-1:0] stk[$];
  logic [PTR_W-1:0] stack_level;
  scrx_fetch_t fetch_ctl;
  logic core_reset;
  int fails = 0;
  int check_count = 0;

  scrx_exec i_dut (.core_clk(core_clk), .rst(rst), .instr_word(instr_word), .pc_cur(pc_cur),
    .fetch_ctl(fetch_ctl), .stack_top_entry(stack_top_entry), .stack_level(stack_level),
    .core_reset(core_reset));
  scrx_fetch_model #(.START_PC(START)) i_fetch (.core_clk(core_clk), .rst(rst), .fetch_ctl(fetch_ctl),
    .core_reset(core_reset), .pc_cur(pc_cur));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      @(negedge core_clk);
    end
  endtask

  function automatic logic [PC_W-1:0] top_now();
    return (stk.size() > 0) ? stk[$] : PC_ZERO;
  endfunction

  // One single-cycle instruction; the stack moves at the end of phase k
  task automatic one_op(input logic [15:0] w, input int k);
    int lvl;
    lvl = stk.size();
    instr_word = w;
    if (w == OPC_PUSH && lvl < 31) stk.push_back(exp_pc + PC_STEP);
    if (w == OPC_POP && lvl > 0) void'(stk.pop_back());
    step(1);
    instr_word = OPC_NOP;
    step(k - 2);
    chk("level_before", stack_level, lvl);
    step(1);
    chk("level", stack_level, stk.size());
    chk("top", stack_top_entry, top_now());
    step(4 - k);
    exp_pc = exp_pc + PC_STEP;
  endtask

  task automatic do_call(input logic [10:0] n);
    logic [PC_W-1:0] tgt;
    tgt = exp_pc + PC_STEP + {{(PC_W-12){n[10]}}, n, 1'b0};
    instr_word = {CALL_PREFIX, n};
    stk.push_back(exp_pc + PC_STEP);
    step(1);
    instr_word = OPC_NOP;
    step(1);
    chk("call_top", stack_top_entry, top_now());
    chk("call_level", stack_level, stk.size());
    chk("early_load", fetch_ctl.load, 1'b0);
    step(1);
    chk("load", fetch_ctl.load, 1'b1);
    chk("target", fetch_ctl.addr, tgt);
    step(1);
    chk("flush", fetch_ctl.flush, 1'b1);
    // A word offered in the dead cycle must be ignored
    instr_word = OPC_PUSH;
    step(1);
    instr_word = OPC_NOP;
    step(2);
    chk("flush_last", fetch_ctl.flush, 1'b1);
    step(1);
    chk("flush_off", fetch_ctl.flush, 1'b0);
    chk("flush_level", stack_level, stk.size());
    exp_pc = tgt;
  endtask

  task automatic do_reset();
    instr_word = OPC_RESET;
    step(1);
    instr_word = OPC_NOP;
    chk("early_reset", core_reset, 1'b0);
    step(1);
    chk("core_reset", core_reset, 1'b1);
    step(1);
    chk("rst_level", stack_level, 5'h00);
    chk("rst_top", stack_top_entry, PC_ZERO);
    stk.delete();
    exp_pc = START;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 2000);
    fails++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    exp_pc = START;
    one_op(OPC_PUSH, 2);
    one_op(OPC_PUSH, 2);
    one_op(OPC_NOP, 4);
    one_op(16'hF123, 4);
    one_op(16'hFFFF, 4);
    one_op(16'hD7FF, 4);
    one_op(OPC_POP, 3);
    do_call(11'h3FF);
    do_call(11'h400);
    do_call(11'h001);
    do_reset();
    one_op(OPC_PUSH, 2);
    one_op(OPC_POP, 3);
    one_op(OPC_POP, 3);
    repeat (32) one_op(OPC_PUSH, 2);
    do_reset();
    final_report();
  end
endmodule
